// >>> core/bmd_pkg.sv
// Shared constants, state codes and carrier types for the branch and multiply decoder
package bmd_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Widths
    localparam int PC_W = 12;
    localparam int DATA_W = 16;
    localparam int ACC_W = 32;
    localparam int DA_W = 8;
    localparam int K_W = 13;
    localparam int MODE_BIT = 7;
    localparam int STACK_DEPTH_DEF = 4;

    ////////////////////////////////////////////////////////////////////////////
    // Two-word branch family: upper byte of the first word, low byte zero
    localparam logic [7:0] OP_BRANCH_ALWAYS = 8'hf9;
    localparam logic [7:0] OP_CALL_IMMEDIATE = 8'hf8;
    localparam logic [7:0] OP_BRANCH_AUX_NONZERO = 8'hf4;
    localparam logic [7:0] OP_BRANCH_ACC_NONNEG = 8'hfd;
    localparam logic [7:0] OP_BRANCH_ACC_POSITIVE = 8'hfc;
    localparam logic [7:0] OP_BRANCH_POLL_LOW = 8'hf6;
    localparam logic [7:0] OP_BRANCH_ACC_NONPOSITIVE = 8'hfb;
    localparam logic [7:0] OP_BRANCH_ACC_NEGATIVE = 8'hfa;
    localparam logic [7:0] OP_BRANCH_ACC_NONZERO = 8'hfe;
    localparam logic [7:0] OP_BRANCH_ACC_ZERO = 8'hff;
    localparam logic [7:0] OP_BRANCH_LOW_BYTE = 8'h00;
    localparam logic [3:0] TARGET_TOP_NIBBLE = 4'h0;

    ////////////////////////////////////////////////////////////////////////////
    // One-word opcodes
    localparam logic [15:0] OP_CALL_FROM_ACCUMULATOR = 16'h7f8c;
    localparam logic [15:0] OP_RETURN = 16'h7f8d;
    localparam logic [15:0] OP_LOAD_ACC_FROM_PRODUCT = 16'h7f8e;
    localparam logic [15:0] OP_ADD_PRODUCT = 16'h7f8f;
    localparam logic [15:0] OP_SUBTRACT_PRODUCT = 16'h7f90;
    localparam logic [7:0] OP_LOAD_MULTIPLICAND = 8'h6a;
    localparam logic [7:0] OP_LOAD_MULT_ACCUMULATE = 8'h6c;
    localparam logic [7:0] OP_LOAD_MULT_ACC_SHIFT = 8'h6b;
    localparam logic [7:0] OP_MULTIPLY_MEMORY = 8'h6d;
    localparam logic [2:0] OP_MULTIPLY_IMMEDIATE = 3'b100;

    ////////////////////////////////////////////////////////////////////////////
    // Values after reset
    localparam logic [PC_W-1:0] PC_RST = 12'h000;
    localparam logic [ACC_W-1:0] ACC_RST = 32'h0000_0000;
    localparam logic [DATA_W-1:0] TREG_RST = 16'h0000;
    localparam logic [ACC_W-1:0] PREG_RST = 32'h0000_0000;

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer states and carriers
    typedef enum logic [2:0] {
        ST_EXEC = 3'b001,
        ST_WORD2 = 3'b010,
        ST_SUB2 = 3'b100
    } bmd_state_t;

    typedef struct packed {
        logic en;
        logic [DA_W-1:0] addr;
        logic [DATA_W-1:0] word;
    } bmd_dm_wr_t;

endpackage : bmd_pkg

// >>> core/bmd_stack.sv
// Return-address stack held in flip-flops with a wrapping pointer
`timescale 1ns/10ps
module bmd_stack #(
    parameter int DEPTH = 4,
    parameter int W = 12
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic push,
    input wire logic pop,
    input wire logic [W-1:0] push_word,
    output logic [W-1:0] top_word
);

    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [PW-1:0] ptr_r;
    logic [W-1:0] mem_r [DEPTH];

    ////////////////////////////////////////////////////////////////////////////
    // Pointer moves up on push, down on pop; overflow drops the oldest entry
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
            ptr_r <= '0;
        else if (push)
            ptr_r <= PW'(ptr_r + 1'b1);
        else if (pop)
            ptr_r <= PW'(ptr_r - 1'b1);
    end

    // Entry storage
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            for (int i = 0; i < DEPTH; i++)
                mem_r[i] <= '0;
        end
        else if (push)
            mem_r[PW'(ptr_r + 1'b1)] <= push_word;
    end

    assign top_word = mem_r[ptr_r];

endmodule : bmd_stack

// >>> core/bmd_mult.sv
// Signed multiplier with operand selection between data word and immediate field
`timescale 1ns/10ps
module bmd_mult (
    input wire logic [15:0] treg,
    input wire logic [15:0] data_word,
    input wire logic [15:0] instr_word,
    input wire logic sel_imm,
    output logic [31:0] product
);

    logic [15:0] oper_b;

    ////////////////////////////////////////////////////////////////////////////
    // Immediate is the low 13 bits, sign-extended
    assign oper_b = sel_imm ? {{3{instr_word[12]}}, instr_word[12:0]} : data_word;
    assign product = $signed({{16{treg[15]}}, treg}) * $signed({{16{oper_b[15]}}, oper_b});

endmodule : bmd_mult

// >>> core/bmd_core.sv
// Branch and multiply group sequencer with accumulator, multiplicand and product registers
`timescale 1ns/10ps
module bmd_core #(
    parameter int STACK_DEPTH = bmd_pkg::STACK_DEPTH_DEF,
    parameter bit POLL_PRESENT = 1'b1
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic [15:0] instr_word,
    input wire logic [15:0] data_rd_word,
    input wire logic [15:0] aux_value,
    input wire logic data_page,
    input wire logic poll_input_pin_n,
    input wire logic acc_load_en,
    input wire logic [31:0] acc_load_word,
    output logic [11:0] prog_addr,
    output logic [7:0] data_rd_addr,
    output bmd_pkg::bmd_dm_wr_t dm_wr,
    output logic [31:0] acc,
    output logic [15:0] treg,
    output logic [31:0] preg
);

    ////////////////////////////////////////////////////////////////////////////
    // Declarations
    bmd_pkg::bmd_state_t st_r;
    logic [bmd_pkg::PC_W-1:0] pc_r;
    logic [bmd_pkg::PC_W-1:0] sub_target_r;
    logic br_take_r;
    logic call_imm_r;
    logic [bmd_pkg::ACC_W-1:0] acc_r;
    logic [bmd_pkg::DATA_W-1:0] treg_r;
    logic [bmd_pkg::ACC_W-1:0] preg_r;
    bmd_pkg::bmd_dm_wr_t dm_wr_r;
    logic poll_meta_r;
    logic poll_sync_r;
    logic exec;
    logic two_word;
    logic stack_push;
    logic stack_pop;
    logic [bmd_pkg::PC_W-1:0] push_word;
    logic [bmd_pkg::PC_W-1:0] stack_top;
    logic [bmd_pkg::ACC_W-1:0] mult_p;
    logic sel_imm;
    logic [7:0] op_hi;

    ////////////////////////////////////////////////////////////////////////////
    // Direct address is page bit plus seven low bits; indirect uses the auxiliary register
    function automatic logic [bmd_pkg::DA_W-1:0] data_addr(input logic [15:0] word, input logic page,
                                                          input logic [15:0] aux);
        if (word[bmd_pkg::MODE_BIT])
            data_addr = aux[bmd_pkg::DA_W-1:0];
        else
            data_addr = {page, word[6:0]};
    endfunction : data_addr

    // True for a two-word branch family first word
    function automatic logic is_branch_word(input logic [15:0] word);
        logic hit;
        hit = 1'b0;
        case (word[15:8])
            bmd_pkg::OP_BRANCH_ALWAYS, bmd_pkg::OP_CALL_IMMEDIATE, bmd_pkg::OP_BRANCH_AUX_NONZERO,
            bmd_pkg::OP_BRANCH_ACC_NONNEG, bmd_pkg::OP_BRANCH_ACC_POSITIVE, bmd_pkg::OP_BRANCH_POLL_LOW,
            bmd_pkg::OP_BRANCH_ACC_NONPOSITIVE, bmd_pkg::OP_BRANCH_ACC_NEGATIVE,
            bmd_pkg::OP_BRANCH_ACC_NONZERO, bmd_pkg::OP_BRANCH_ACC_ZERO:
                hit = 1'b1;
            default:
                hit = 1'b0;
        endcase
        is_branch_word = hit && (word[7:0] == bmd_pkg::OP_BRANCH_LOW_BYTE);
    endfunction : is_branch_word

    // Branch condition from opcode byte and the machine state sampled in the first cycle
    function automatic logic branch_cond(input logic [7:0] op, input logic [31:0] a,
                                         input logic aux_nz, input logic poll_low);
        logic neg;
        logic zero;
        neg = a[31];
        zero = (a == 32'h0000_0000);
        case (op)
            bmd_pkg::OP_BRANCH_AUX_NONZERO: branch_cond = aux_nz;
            bmd_pkg::OP_BRANCH_ACC_NONNEG: branch_cond = !neg;
            bmd_pkg::OP_BRANCH_ACC_POSITIVE: branch_cond = !neg && !zero;
            bmd_pkg::OP_BRANCH_POLL_LOW: branch_cond = POLL_PRESENT && poll_low;
            bmd_pkg::OP_BRANCH_ACC_NONPOSITIVE: branch_cond = neg || zero;
            bmd_pkg::OP_BRANCH_ACC_NEGATIVE: branch_cond = neg;
            bmd_pkg::OP_BRANCH_ACC_NONZERO: branch_cond = !zero;
            bmd_pkg::OP_BRANCH_ACC_ZERO: branch_cond = zero;
            default: branch_cond = 1'b1;
        endcase
    endfunction : branch_cond

    ////////////////////////////////////////////////////////////////////////////
    // Decode helpers
    assign exec = (st_r == bmd_pkg::ST_EXEC);
    assign op_hi = instr_word[15:8];
    assign two_word = exec && is_branch_word(instr_word);
    assign sel_imm = (instr_word[15:13] == bmd_pkg::OP_MULTIPLY_IMMEDIATE);
    assign data_rd_addr = data_addr(instr_word, data_page, aux_value);

    // Polling pin synchroniser, idle high
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            poll_meta_r <= 1'b1;
            poll_sync_r <= 1'b1;
        end
        else
        begin
            poll_meta_r <= poll_input_pin_n;
            poll_sync_r <= poll_meta_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Stack pushes for both calls and pops for return
    always_comb
    begin
        stack_push = 1'b0;
        stack_pop = 1'b0;
        push_word = pc_r + 12'h001;
        if (exec && instr_word == bmd_pkg::OP_CALL_FROM_ACCUMULATOR)
            stack_push = 1'b1;
        else if (exec && instr_word == bmd_pkg::OP_RETURN)
            stack_pop = 1'b1;
        else if (st_r == bmd_pkg::ST_WORD2 && call_imm_r)
            stack_push = 1'b1;
    end

    bmd_stack #(
        .DEPTH(STACK_DEPTH),
        .W(bmd_pkg::PC_W)
    ) u_stack (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .push(stack_push),
        .pop(stack_pop),
        .push_word(push_word),
        .top_word(stack_top)
    );

    bmd_mult u_mult (
        .treg(treg_r),
        .data_word(data_rd_word),
        .instr_word(instr_word),
        .sel_imm(sel_imm),
        .product(mult_p)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer and program counter
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            st_r <= bmd_pkg::ST_EXEC;
            pc_r <= bmd_pkg::PC_RST;
            sub_target_r <= bmd_pkg::PC_RST;
            br_take_r <= 1'b0;
            call_imm_r <= 1'b0;
        end
        else
        begin
            case (st_r)
                bmd_pkg::ST_EXEC:
                begin
                    pc_r <= pc_r + 12'h001;
                    if (two_word)
                    begin
                        br_take_r <= branch_cond(op_hi, acc_r, aux_value != 16'h0000, !poll_sync_r);
                        call_imm_r <= (op_hi == bmd_pkg::OP_CALL_IMMEDIATE);
                        st_r <= bmd_pkg::ST_WORD2;
                    end
                    else if (instr_word == bmd_pkg::OP_CALL_FROM_ACCUMULATOR)
                    begin
                        sub_target_r <= acc_r[bmd_pkg::PC_W-1:0];
                        st_r <= bmd_pkg::ST_SUB2;
                    end
                    else if (instr_word == bmd_pkg::OP_RETURN)
                    begin
                        sub_target_r <= stack_top;
                        st_r <= bmd_pkg::ST_SUB2;
                    end
                end
                bmd_pkg::ST_WORD2:
                begin
                    // Second word: target in low bits, else fall through
                    if (br_take_r)
                        pc_r <= instr_word[bmd_pkg::PC_W-1:0];
                    else
                        pc_r <= pc_r + 12'h001;
                    st_r <= bmd_pkg::ST_EXEC;
                end
                bmd_pkg::ST_SUB2:
                begin
                    pc_r <= sub_target_r;
                    st_r <= bmd_pkg::ST_EXEC;
                end
                default:
                    st_r <= bmd_pkg::ST_EXEC;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Accumulator, multiplicand and product registers
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            acc_r <= bmd_pkg::ACC_RST;
            treg_r <= bmd_pkg::TREG_RST;
            preg_r <= bmd_pkg::PREG_RST;
        end
        else if (exec)
        begin
            if (instr_word == bmd_pkg::OP_ADD_PRODUCT)
                acc_r <= acc_r + preg_r;
            else if (instr_word == bmd_pkg::OP_LOAD_ACC_FROM_PRODUCT)
                acc_r <= preg_r;
            else if (instr_word == bmd_pkg::OP_SUBTRACT_PRODUCT)
                acc_r <= acc_r - preg_r;
            else if (op_hi == bmd_pkg::OP_LOAD_MULTIPLICAND)
                treg_r <= data_rd_word;
            else if (op_hi == bmd_pkg::OP_LOAD_MULT_ACCUMULATE || op_hi == bmd_pkg::OP_LOAD_MULT_ACC_SHIFT)
            begin
                treg_r <= data_rd_word;
                acc_r <= acc_r + preg_r;
            end
            else if (op_hi == bmd_pkg::OP_MULTIPLY_MEMORY || sel_imm)
                preg_r <= mult_p;
            else if (acc_load_en)
                acc_r <= acc_load_word;
        end
    end

    // Data move write one address up, issued the cycle after the instruction
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
            dm_wr_r <= '0;
        else
        begin
            dm_wr_r.en <= exec && (op_hi == bmd_pkg::OP_LOAD_MULT_ACC_SHIFT);
            dm_wr_r.addr <= bmd_pkg::DA_W'(data_rd_addr + 8'h01);
            dm_wr_r.word <= data_rd_word;
        end
    end

    assign prog_addr = pc_r;
    assign dm_wr = dm_wr_r;
    assign acc = acc_r;
    assign treg = treg_r;
    assign preg = preg_r;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    aux_branch_taken_a: assert property ((exec && instr_word == 16'hf400 && aux_value != 16'h0000) |=>
        br_take_r ##1 (st_r == bmd_pkg::ST_EXEC && pc_r == $past(instr_word[11:0])))
        else $error("aux nonzero branch not taken");

    positive_fallthrough_a: assert property ((exec && instr_word == 16'hfc00 && $signed(acc_r) <= 0) |=>
        (!br_take_r && st_r == bmd_pkg::ST_WORD2) ##1 (pc_r == $past(pc_r, 2) + 12'h002))
        else $error("positive branch wrongly taken or wrong fall through");

    negative_branch_a: assert property ((exec && instr_word == 16'hfa00) |=>
        (br_take_r == $past(acc_r[31])))
        else $error("negative branch condition wrong");

    poll_branch_a: assert property ((exec && instr_word == 16'hf600) |=>
        (br_take_r == (POLL_PRESENT && !$past(poll_sync_r))))
        else $error("polling branch condition wrong");

    call_acc_a: assert property ((exec && instr_word == 16'h7f8c) |=> st_r == bmd_pkg::ST_SUB2 ##1
        (pc_r == $past(acc_r[11:0], 2) && stack_top == $past(pc_r, 2) + 12'h001))
        else $error("call from accumulator wrong");

    return_pop_a: assert property ((exec && instr_word == 16'h7f8d) |=>
        ##1 (pc_r == $past(stack_top, 2)))
        else $error("return address wrong");

    add_product_a: assert property ((exec && instr_word == 16'h7f8f) |=>
        acc_r == $past(acc_r) + $past(preg_r))
        else $error("add product wrong");

    sub_product_a: assert property ((exec && instr_word == 16'h7f90) |=>
        acc_r == $past(acc_r) - $past(preg_r))
        else $error("subtract product wrong");

    mult_imm_a: assert property ((exec && instr_word[15:13] == 3'b100) |=>
        preg_r == 32'($signed($past(treg_r)) * $signed({{3{$past(instr_word[12])}}, $past(instr_word[12:0])})))
        else $error("immediate multiply wrong");

    shift_up_write_a: assert property ((exec && instr_word[15:8] == 8'h6b) |=>
        (dm_wr_r.en && dm_wr_r.addr == 8'($past(data_rd_addr) + 8'h01) && treg_r == $past(data_rd_word)))
        else $error("data move write wrong");

endmodule : bmd_core

// >>> tb/bmd_prog_mem.sv
// Program memory model: combinational read of the word at the program address
`timescale 1ns/10ps
module bmd_prog_mem (
    input wire logic [11:0] prog_addr,
    output logic [15:0] instr_word
);
    logic [15:0] mem [0:4095];

    ////////////////////////////////////////////////////////////////////////////
    // Unwritten places hold a word that no decoder group claims
    initial
    begin
        for (int i = 0; i < 4096; i++)
            mem[i] = 16'h7f80;
    end

    // Word at the address, same cycle; branch first word and address word come from consecutive places
    assign instr_word = mem[prog_addr];
endmodule : bmd_prog_mem

// >>> tb/testbench.sv
// Self-checking bench for the branch and multiply decoder
`timescale 1ns/10ps
module testbench;
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [15:0] instr_word;
    logic [15:0] data_rd_word = 16'h0000;
    logic [15:0] aux_value = 16'h0000;
    logic data_page = 1'b0;
    logic poll_input_pin_n = 1'b1;
    logic acc_load_en = 1'b0;
    logic [31:0] acc_load_word = 32'h0000_0000;
    logic [11:0] prog_addr;
    logic [7:0] data_rd_addr;
    bmd_pkg::bmd_dm_wr_t dm_wr;
    logic [31:0] acc;
    logic [15:0] treg;
    logic [31:0] preg;
    integer seed = 63499;
    int n_fail = 0;
    int checked = 0;
    int cycles = 0;
    logic signed [31:0] m_acc, m_p;
    logic signed [15:0] m_t;
    logic [11:0] m_pc, p1, p2, p3, tgt;
    logic m_wr;
    logic [7:0] ops [10] = '{8'hf4, 8'hfd, 8'hfc, 8'hf6, 8'hfb, 8'hfa, 8'hfe, 8'hff, 8'hf9, 8'hf8};

    ////////////////////////////////////////////////////////////////////////////
    // Clock, design and program memory
    always #2 core_clk = ~core_clk;

    bmd_core DUT (.core_clk(core_clk), .reset_n(reset_n), .instr_word(instr_word),
        .data_rd_word(data_rd_word), .aux_value(aux_value), .data_page(data_page),
        .poll_input_pin_n(poll_input_pin_n), .acc_load_en(acc_load_en), .acc_load_word(acc_load_word),
        .prog_addr(prog_addr), .data_rd_addr(data_rd_addr), .dm_wr(dm_wr), .acc(acc), .treg(treg),
        .preg(preg));

    bmd_prog_mem PM (.prog_addr(prog_addr), .instr_word(instr_word));

    ////////////////////////////////////////////////////////////////////////////
    // Checking helpers
    task report_and_stop;
        $display("checked=%0d n_fail=%0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : report_and_stop

    task chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            n_fail++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Branch condition worked out from the accumulator, aux register and poll pin
    function automatic logic taken(logic [7:0] op, logic signed [31:0] a, logic [15:0] x, logic pl);
        case (op)
            8'hf4: return x != 16'h0000;
            8'hfd: return a >= 0;
            8'hfc: return a > 0;
            8'hf6: return pl == 1'b0;
            8'hfb: return a <= 0;
            8'hfa: return a < 0;
            8'hfe: return a != 0;
            8'hf9, 8'hf8: return 1'b1;
            default: return a == 0;
        endcase
    endfunction : taken

    // Present one word, let the edge pass, compare program address, accumulator, multiplicand, product and write enable with the model
    task step(input logic [15:0] w);
        PM.mem[prog_addr] = w;
        @(posedge core_clk);
        #1;
        chk({20'h0, prog_addr}, {20'h0, m_pc});
        chk(acc, m_acc);
        chk({16'h0, treg}, {16'h0, m_t});
        chk(preg, m_p);
        chk({31'h0, dm_wr.en}, {31'h0, m_wr});
    endtask : step

    // Load the accumulator from another group during an unclaimed word
    task ld_acc(input logic [31:0] v);
        acc_load_en = 1'b1;
        acc_load_word = v;
        m_acc = v;
        m_pc = m_pc + 12'h001;
        step(16'h7f80);
        acc_load_en = 1'b0;
    endtask : ld_acc

    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 6000)
        begin
            n_fail++;
            report_and_stop;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        logic [31:0] v;
        logic [15:0] d, w;
        logic [7:0] ea;
        logic t, pl;
        m_acc = 0;
        m_p = 0;
        m_t = 0;
        m_pc = 12'h000;
        m_wr = 1'b0;
        repeat (10) @(posedge core_clk);
        #1;
        reset_n = 1'b1;
        chk({20'h0, prog_addr}, 32'h0);
        // Every branch opcode with zero, positive, negative and random accumulators
        for (int i = 0; i < 10; i++)
        begin
            for (int j = 0; j < 4; j++)
            begin
                v = (j == 0) ? 32'h0 : (j == 1) ? ($random(seed) & 32'h7fff_ffff) | 32'h1 :
                    (j == 2) ? $random(seed) | 32'h8000_0000 : $random(seed);
                aux_value = (j % 2 == 1) ? 16'h0000 : $random(seed);
                pl = $random(seed);
                poll_input_pin_n = pl;
                ld_acc(v);
                m_pc = m_pc + 12'h001;
                step(16'h7f80);
                m_pc = m_pc + 12'h001;
                step(16'h7f80);
                tgt = $random(seed);
                t = taken(ops[i], v, aux_value, pl);
                p1 = m_pc;
                m_pc = p1 + 12'h001;
                step({ops[i], 8'h00});
                m_pc = t ? tgt : p1 + 12'h002;
                step({4'h0, tgt});
            end
        end
        // Return address left on the stack by the last immediate call
        p3 = p1 + 12'h002;
        // Multiplier group in random order
        for (int i = 0; i < 80; i++)
        begin
            d = $random(seed);
            data_rd_word = d;
            aux_value = $random(seed);
            data_page = $random(seed);
            w = $random(seed);
            ea = w[7] ? aux_value[7:0] : {data_page, w[6:0]};
            m_pc = m_pc + 12'h001;
            case ($unsigned($random(seed)) % 8)
                0: begin w = {8'h6c, w[7:0]}; m_t = d; m_acc = m_acc + m_p; end
                1: begin w = {8'h6b, w[7:0]}; m_t = d; m_acc = m_acc + m_p; m_wr = 1'b1; end
                2: begin w = {8'h6d, w[7:0]}; m_p = m_t * $signed(d); end
                3: begin w = {3'b100, w[12:0]}; m_p = m_t * $signed({{3{w[12]}}, w[12:0]}); end
                4: begin w = 16'h7f8e; m_acc = m_p; end
                5: begin w = 16'h7f8f; m_acc = m_acc + m_p; end
                6: begin w = 16'h7f90; m_acc = m_acc - m_p; end
                default: begin w = {8'h6a, w[7:0]}; m_t = d; end
            endcase
            PM.mem[prog_addr] = w;
            #0.1;
            if (w[15:13] != 3'b100 && w[15:8] != 8'h7f)
                chk({24'h0, data_rd_addr}, {24'h0, ea});
            step(w);
            if (m_wr)
            begin
                chk({24'h0, dm_wr.addr}, {24'h0, ea + 8'h01});
                chk({16'h0, dm_wr.word}, {16'h0, d});
            end
            m_wr = 1'b0;
        end
        // Nested calls from the accumulator, then returns in reverse order
        tgt = $random(seed);
        ld_acc({20'($random(seed)), tgt});
        p1 = m_pc;
        m_pc = p1 + 12'h001;
        step(16'h7f8c);
        m_pc = m_acc[11:0];
        step($random(seed));
        ld_acc($random(seed));
        p2 = m_pc;
        m_pc = p2 + 12'h001;
        step(16'h7f8c);
        m_pc = m_acc[11:0];
        step($random(seed));
        m_pc = m_pc + 12'h001;
        step(16'h7f8d);
        m_pc = p2 + 12'h001;
        step($random(seed));
        m_pc = m_pc + 12'h001;
        step(16'h7f8d);
        m_pc = p1 + 12'h001;
        step($random(seed));
        // Third return pops the address pushed by the immediate call
        m_pc = m_pc + 12'h001;
        step(16'h7f8d);
        m_pc = p3;
        step(16'h7f80);
        report_and_stop;
    end
endmodule : testbench
